// ===== logic/bgc_block_gating.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none
module bgc_block_gating
  import bgc_pkg::*;
#(
  parameter bit OSCDET_ALWAYS = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bgc_wake_t wake_req,
  input wire logic irq_pending,
  input wire logic master_irq_enable,
  input wire logic [1:0] interrupt_level_field,
  input wire logic reset_cause_break,
  input wire logic sys_reset_done,
  output bgc_gate_t periph_reset,
  output bgc_gate_t periph_clk_en,
  output logic cpu_halted,
  output logic irq_service_ok,
  output logic [15:0] start_vector
);
  logic [31:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic [7:0] sound_r;
  logic [7:0] analog_r;
  bgc_mode_t mode_r;
  bgc_mode_t mode_nxt;
  logic wake_any;
  logic [7:0] wr_byte;
  logic do_write;
  logic halt_wr;
  bgc_gate_t gate_nxt;

  function automatic logic [7:0] lane_byte(input logic [31:0] addr, input logic [31:0] data);
    // Each register owns a whole word; the byte sits in the low lane.
    lane_byte = data[7:0];
  endfunction

  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_byte = lane_byte(aw_addr_r, w_data_r);
  assign wake_any = wake_req.nmi || wake_req.wdt || wake_req.maskable;
  // A write with both halt and stop set is prohibited and treated as no entry.
  assign halt_wr = do_write && w_strb_r[0] && aw_addr_r == BGC_STBY_ADDR
                   && wr_byte[BGC_HALT_BIT] && !wr_byte[BGC_STOP_BIT];

  // Address and data are held separately so they may arrive in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_r && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_wready <= !w_have_r && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BGC_RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == BGC_SOUND_ADDR || aw_addr_r == BGC_ANALOG_ADDR
                        || aw_addr_r == BGC_STBY_ADDR) ? BGC_RESP_OKAY : BGC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sound_r <= BGC_SOUND_RST;
      analog_r <= BGC_ANALOG_RST;
    end else if (clk_en && do_write && w_strb_r[0]) begin
      if (aw_addr_r == BGC_SOUND_ADDR) begin
        sound_r <= wr_byte & BGC_SOUND_MASK;
      end
      if (aw_addr_r == BGC_ANALOG_ADDR) begin
        analog_r <= wr_byte & BGC_ANALOG_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= BGC_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= BGC_RESP_OKAY;
        case (s_axi_araddr)
          BGC_SOUND_ADDR: s_axi_rdata <= {24'h00_0000, sound_r};
          BGC_ANALOG_ADDR: s_axi_rdata <= {24'h00_0000, analog_r};
          // Standby control is write-only; the live mode is shown at the status word.
          BGC_STBY_ADDR: s_axi_rdata <= 32'h0000_0000;
          BGC_STATUS_ADDR: s_axi_rdata <= {30'h0, mode_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= BGC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      BGC_RUN: begin
        if (halt_wr && !irq_pending) begin
          mode_nxt = BGC_HALT;
        end
      end
      BGC_HALT: begin
        if (wake_any) begin
          mode_nxt = BGC_WAKE;
        end
      end
      // One cycle standing for the falling-edge release before run resumes.
      BGC_WAKE: mode_nxt = BGC_RUN;
      default: mode_nxt = BGC_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= BGC_RUN;
      cpu_halted <= 1'b0;
      irq_service_ok <= 1'b0;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
      cpu_halted <= mode_nxt == BGC_HALT;
      if (mode_r == BGC_HALT && wake_any) begin
        // Interrupt service follows only if the core would accept it.
        irq_service_ok <= wake_req.nmi || wake_req.wdt
                          || (wake_req.maskable && master_irq_enable);
      end else begin
        irq_service_ok <= 1'b0;
      end
    end
  end

  always_comb begin
    gate_nxt.buzzer = sound_r[BGC_BUZZER_BIT];
    gate_nxt.display = analog_r[BGC_DISPLAY_BIT];
    gate_nxt.battery = analog_r[BGC_BATTERY_BIT];
    gate_nxt.oscdet = analog_r[BGC_OSCDET_BIT]
                      && (OSCDET_ALWAYS || mode_nxt == BGC_HALT);
    gate_nxt.rc_adc = analog_r[BGC_RC_BIT];
    gate_nxt.sar_adc = analog_r[BGC_SAR_BIT];
  end

  // Reset held high keeps the peripheral's registers at initial values and
  // blocks its register writes; clock enable low stops its operating clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_reset <= '0;
      periph_clk_en <= '1;
    end else if (clk_en) begin
      periph_reset <= gate_nxt;
      periph_clk_en <= ~gate_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_vector <= BGC_VEC_NORMAL;
    end else if (clk_en && sys_reset_done) begin
      if (reset_cause_break && interrupt_level_field < BGC_LEVEL_NMI) begin
        start_vector <= BGC_VEC_BREAK;
      end else begin
        start_vector <= BGC_VEC_NORMAL;
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/bgc_pkg.sv
// Functional notes
// - Disabled peripheral held in reset, clock stopped
// - Disabled peripheral ignores writes, reads initial values
// - Sound disable register, bit 0 buzzer
// - Analog disable register resets to zero
// - Bit 6 turns display driver off
// - Bit 5 turns battery detector off
// - Bit 4 gates stop detector only in halt
// - Variant gates stop detector in all modes
// - Bit 1 turns RC converter off
// - Bit 0 turns SAR converter off
// - Ordinary resets start from vector 0002H
// - Break reset starts from vector 0004H
// - Break at level two or more uses 0002H
// - Halt bit stops execution, peripherals run
// - Wake request clears halt bit, resumes run
// - Up to two instructions before interrupt entry
// - Halt is bit 0 of standby control
// - No halt while enabled request pending
// - Maskable wake with master enable low skips service
`default_nettype none
package bgc_pkg;
  localparam logic [31:0] BGC_SOUND_OFS = 32'h0000_F02B;
  localparam logic [31:0] BGC_ANALOG_OFS = 32'h0000_F02C;
  localparam logic [31:0] BGC_STBY_OFS = 32'h0000_F009;
  localparam logic [31:0] BGC_STATUS_OFS = 32'h0000_F030;
  localparam logic [31:0] BGC_SOUND_ADDR = BGC_SOUND_OFS << 2;
  localparam logic [31:0] BGC_ANALOG_ADDR = BGC_ANALOG_OFS << 2;
  localparam logic [31:0] BGC_STBY_ADDR = BGC_STBY_OFS << 2;
  localparam logic [31:0] BGC_STATUS_ADDR = BGC_STATUS_OFS << 2;
  localparam logic [7:0] BGC_SOUND_RST = 8'h00;
  localparam logic [7:0] BGC_ANALOG_RST = 8'h00;
  localparam logic [7:0] BGC_SOUND_MASK = 8'h01;
  localparam logic [7:0] BGC_ANALOG_MASK = 8'h73;
  localparam int BGC_BUZZER_BIT = 0;
  localparam int BGC_DISPLAY_BIT = 6;
  localparam int BGC_BATTERY_BIT = 5;
  localparam int BGC_OSCDET_BIT = 4;
  localparam int BGC_RC_BIT = 1;
  localparam int BGC_SAR_BIT = 0;
  localparam int BGC_HALT_BIT = 0;
  localparam int BGC_STOP_BIT = 1;
  localparam logic [15:0] BGC_VEC_NORMAL = 16'h0002;
  localparam logic [15:0] BGC_VEC_BREAK = 16'h0004;
  localparam logic [1:0] BGC_LEVEL_NMI = 2'h2;
  localparam logic [1:0] BGC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BGC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    BGC_RUN = 2'b00,
    BGC_HALT = 2'b01,
    BGC_WAKE = 2'b10
  } bgc_mode_t;
  typedef struct packed {
    logic display;
    logic battery;
    logic oscdet;
    logic rc_adc;
    logic sar_adc;
    logic buzzer;
  } bgc_gate_t;
  typedef struct packed {
    logic nmi;
    logic wdt;
    logic maskable;
  } bgc_wake_t;
endpackage
`default_nettype wire

// ===== sim/bgc_block_gating_properties.sv
`default_nettype none
module bgc_block_gating_properties
  import bgc_pkg::*;
#(
  parameter bit OSCDET_ALWAYS = 1'h0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire bgc_wake_t wake_req,
  input wire logic irq_pending,
  input wire logic master_irq_enable,
  input wire logic [1:0] interrupt_level_field,
  input wire logic reset_cause_break,
  input wire logic sys_reset_done,
  input wire bgc_gate_t periph_reset,
  input wire bgc_gate_t periph_clk_en,
  input wire logic cpu_halted,
  input wire logic irq_service_ok,
  input wire logic [15:0] start_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_clk_inverse: assert property (periph_clk_en == ~periph_reset)
    else $error("clock enable not inverse of reset");
  a_halt_guard: assert property ($rose(cpu_halted) |-> !$past(irq_pending))
    else $error("halt entered with request pending");
  a_wake_exit: assert property (cpu_halted && (|wake_req) |=> !cpu_halted)
    else $error("halt not left on wake");
  a_nmi_service: assert property (cpu_halted && wake_req.nmi |-> ##[1:2] irq_service_ok)
    else $error("no service after nmi wake");
  a_mie_skip: assert property (cpu_halted && wake_req == 3'h1 && !master_irq_enable
    |=> !irq_service_ok ##1 !irq_service_ok) else $error("service with master enable low");
  a_vec_normal: assert property (clk_en && sys_reset_done && !(reset_cause_break
    && interrupt_level_field < 2) |=> start_vector == BGC_VEC_NORMAL) else $error("vector");
  a_vec_break: assert property (clk_en && sys_reset_done && reset_cause_break
    && interrupt_level_field < 2 |=> start_vector == BGC_VEC_BREAK) else $error("vector");
  // Three idle cycles leave room for the registered gate to follow a halt exit.
  a_oscdet_run: assert property ((!cpu_halted)[*3]
    |-> OSCDET_ALWAYS || !periph_reset.oscdet) else $error("stop detector off outside halt");
endmodule
bind bgc_block_gating bgc_block_gating_properties #(.OSCDET_ALWAYS(OSCDET_ALWAYS))
  bgc_block_gating_properties_inst (.*);
`default_nettype wire

// ===== sim/bgc_core_model.sv
`default_nettype none
module bgc_core_model
  import bgc_pkg::*;
(
  input wire logic aclk,
  output bgc_wake_t wake_req,
  output logic irq_pending,
  output logic master_irq_enable,
  output logic [1:0] interrupt_level_field,
  output logic reset_cause_break,
  output logic sys_reset_done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {wake_req, irq_pending, interrupt_level_field, reset_cause_break, sys_reset_done} = '0;
    master_irq_enable = 1'h1;
  end
  task automatic set(input bgc_wake_t w, input logic p, input logic m);
    @(posedge aclk);
    wake_req <= w;
    irq_pending <= p | w.maskable;
    master_irq_enable <= m;
  endtask
  task automatic boot(input logic b, input logic [1:0] l);
    @(posedge aclk);
    reset_cause_break <= b;
    interrupt_level_field <= l;
    sys_reset_done <= 1'h1;
    @(posedge aclk);
    sys_reset_done <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== sim/block_gating_and_halt_control_tb.sv
`default_nettype none
module block_gating_and_halt_control_tb;
  import bgc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, interrupt_level_field, rr, br;
  bgc_wake_t wake_req;
  logic irq_pending, master_irq_enable, reset_cause_break, sys_reset_done;
  bgc_gate_t periph_reset, periph_clk_en;
  logic cpu_halted, irq_service_ok;
  logic [15:0] start_vector;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] ta [7] = '{BGC_SOUND_ADDR, BGC_SOUND_ADDR, BGC_ANALOG_ADDR, BGC_ANALOG_ADDR,
    BGC_ANALOG_ADDR, BGC_ANALOG_ADDR, BGC_ANALOG_ADDR};
  logic [7:0] tw [7] = '{8'hFF, 8'h00, 8'h40, 8'h20, 8'h02, 8'h01, 8'hFF};
  logic [15:0] tq [7] = '{16'h1, 16'h0, 16'h40, 16'h20, 16'h2, 16'h1, 16'h73};
  logic [5:0] tg [7] = '{6'h01, 6'h00, 6'h20, 6'h10, 6'h04, 6'h02, 6'h36};
  bgc_block_gating #(.OSCDET_ALWAYS(1'h0)) bgc_block_gating_inst (.*);
  bgc_core_model bgc_core_model_inst (.*);
  bgc_gate_t alt_reset;
  // A second copy built as the variant whose stop detector is gated in every mode.
  bgc_block_gating #(.OSCDET_ALWAYS(1'h1)) bgc_block_gating_alt_inst (.aclk(aclk),
    .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
    .wake_req(wake_req), .irq_pending(irq_pending), .master_irq_enable(master_irq_enable),
    .interrupt_level_field(interrupt_level_field), .reset_cause_break(reset_cause_break),
    .sys_reset_done(sys_reset_done), .periph_reset(alt_reset), .periph_clk_en(),
    .cpu_halted(), .irq_service_ok(), .start_vector());
  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    q = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rst;
    aresetn <= 1'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    conclude();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    clk_en = 1'h1;
    rst();
    rd(BGC_SOUND_ADDR);
    chk(q[15:0], 16'(BGC_SOUND_RST));
    rd(BGC_ANALOG_ADDR);
    chk(q[15:0], 16'(BGC_ANALOG_RST));
    chk(16'(periph_clk_en), 16'h3F);
    chk(start_vector, BGC_VEC_NORMAL);
    rd(32'h100);
    chk({q[13:0], rr}, 16'(BGC_RESP_SLVERR));
    wr(32'h100, 8'hFF);
    chk(16'(br), 16'(BGC_RESP_SLVERR));
    for (int i = 0; i < 7; i++) begin
      wr(ta[i], tw[i]);
      chk(16'(br), 16'(BGC_RESP_OKAY));
      rd(ta[i]);
      chk(q[15:0], tq[i]);
      chk(16'(periph_reset), 16'(tg[i]));
    end
    chk(16'(alt_reset), 16'h3E);
    // A write whose low strobe is off must leave the register as it was.
    s_axi_wstrb <= 4'h0;
    wr(BGC_ANALOG_ADDR, 8'h00);
    s_axi_wstrb <= 4'hF;
    rd(BGC_ANALOG_ADDR);
    chk(q[15:0], 16'h73);
    // Maskable wake goes in last with the master enable low, so it must skip service.
    for (int k = 0; k < 3; k++) begin
      wr(BGC_STBY_ADDR, 8'h01);
      repeat (2) @(posedge aclk);
      chk(cpu_halted, 1'h1);
      chk(periph_reset.oscdet, 1'h1);
      rd(BGC_ANALOG_ADDR);
      chk(q[15:0], 16'h73);
      rd(BGC_STATUS_ADDR);
      chk(q[15:0], 16'(BGC_HALT));
      bgc_core_model_inst.set(bgc_wake_t'(3'h4 >> k), 1'h0, k < 2);
      repeat (2) @(posedge aclk);
      chk(irq_service_ok, k < 2);
      @(posedge aclk);
      chk(cpu_halted, 1'h0);
      bgc_core_model_inst.set(3'h0, k == 2, 1'h1);
    end
    wr(BGC_STBY_ADDR, 8'h01);
    repeat (3) @(posedge aclk);
    chk(cpu_halted, 1'h0);
    bgc_core_model_inst.set(3'h0, 1'h0, 1'h1);
    wr(BGC_STBY_ADDR, 8'h03);
    repeat (3) @(posedge aclk);
    chk(cpu_halted, 1'h0);
    for (int i = 0; i < 5; i++) begin
      bgc_core_model_inst.boot(i > 0, (i > 0) ? 2'(i - 1) : 2'h0);
      @(posedge aclk);
      chk(start_vector, (i == 1 || i == 2) ? BGC_VEC_BREAK : BGC_VEC_NORMAL);
    end
    // With the clock enable low a boot strobe must not move the vector.
    clk_en <= 1'h0;
    bgc_core_model_inst.boot(1'h1, 2'h0);
    @(posedge aclk);
    chk(start_vector, BGC_VEC_NORMAL);
    clk_en <= 1'h1;
    rst();
    rd(BGC_ANALOG_ADDR);
    chk(q[15:0], 16'(BGC_ANALOG_RST));
    chk(16'(periph_reset), 16'h00);
    conclude();
  end
endmodule
`default_nettype wire
